// ===== dlwm_defines.svh
// constants for the drive limit and warning monitor
`ifndef DLWM_DEFINES_SVH
`define DLWM_DEFINES_SVH

// *****************************************************************
// scaling: percent in 0.01 %, current in 0.1 A, freq in 0.1 Hz,
// feedback in 0.001 units
// *****************************************************************
`define DLWM_PCT_FULL        16'd10000
`define DLWM_CEIL_DEFAULT    16'd16000
`define DLWM_FREQ_MAX_LOW    16'd1320
`define DLWM_FREQ_MAX_HIGH   16'd10000
`define DLWM_FREQ_HI_DEFAULT 16'd1320
`define DLWM_FB_FLOOR        (-40'sd100000000)
`define DLWM_FB_TOP          (40'sd100000000)
`define DLWM_FB_LO_DEFAULT   (-40'sd4000000)
`define DLWM_FB_HI_DEFAULT   (40'sd4000000)
`define DLWM_W_CUR_LO        0
`define DLWM_W_CUR_HI        1
`define DLWM_W_FRQ_LO        2
`define DLWM_W_FRQ_HI        3
`define DLWM_W_FB_LO         4
`define DLWM_W_FB_HI         5
`endif

// ===== dlwm_pkg.sv
// types for the drive limit and warning monitor
package dlwm_pkg;
    // warning vector, one bit per comparison
    typedef logic [5:0] dlwm_warn_t;
    // the four remote reference sources, signed 0.1 Hz
    typedef struct packed {
        logic signed [23:0] preset;
        logic signed [23:0] analogue;
        logic signed [23:0] pulse;
        logic signed [23:0] serial;
    } dlwm_refs_t;
    // drive run state
    typedef enum logic [1:0] {
        DLWM_STOPPED = 2'b00,
        DLWM_RAMPING = 2'b01,
        DLWM_ON_REF  = 2'b11
    } dlwm_run_t;
endpackage : dlwm_pkg

// ===== dlwm_monitor.sv
// limit and warning monitor for a motor frequency converter
`timescale 1ns/100ps
`include "dlwm_defines.svh"
module dlwm_monitor
(
    // clock and reset
    input  wire logic                CLK_SYS,
    input  wire logic                RESETN,
    // reference inputs
    input  wire dlwm_pkg::dlwm_refs_t REFS,
    input  wire logic                CATCH_UP_PIN,
    input  wire logic                SLOW_DOWN_PIN,
    input  wire logic [15:0]         NUDGE_PERCENT,
    // drive state
    input  wire logic                START_CMD,
    input  wire logic                RAMPING,
    input  wire logic [15:0]         OUT_FREQ,
    input  wire logic [15:0]         OUT_CURRENT,
    input  wire logic [15:0]         REQ_CURRENT,
    input  wire logic signed [39:0]  FEEDBACK,
    // settings
    input  wire logic [15:0]         CEILING_PERCENT,
    input  wire logic [15:0]         RATED_CURRENT,
    input  wire logic [15:0]         MAX_CURRENT,
    input  wire logic [15:0]         CUR_WARN_LO,
    input  wire logic [15:0]         CUR_WARN_HI,
    input  wire logic                WIDE_FREQ_RANGE,
    input  wire logic [15:0]         FRQ_WARN_LO,
    input  wire logic [15:0]         FRQ_WARN_HI,
    input  wire logic signed [39:0]  FB_WARN_LO,
    input  wire logic signed [39:0]  FB_WARN_HI,
    input  wire logic [5:0]          DOUT_ROUTE,
    input  wire logic [5:0]          RELAY_ROUTE,
    // results
    output logic signed [23:0]       RESULT_REF,
    output logic [15:0]              CURRENT_LIMITED,
    output logic [15:0]              CURRENT_CEILING,
    output dlwm_pkg::dlwm_warn_t     WARNINGS,
    output logic                     DOUT_WARN,
    output logic                     RELAY_WARN,
    output dlwm_pkg::dlwm_run_t      RUN_STATE
);

    // *****************************************************************
    // pin synchronisers
    // *****************************************************************
    logic [1:0] pin_meta_reg;   // first stage, read only by second
    logic [1:0] pin_sync_reg;   // catch-up [0], slow-down [1]
    logic [1:0] pin_meta_next;
    logic [1:0] pin_sync_next;

    // sample the digital inputs
    always_comb
    begin
        pin_meta_next = {SLOW_DOWN_PIN, CATCH_UP_PIN};
        pin_sync_next = pin_meta_reg;
    end

    // register the synchroniser
    always_ff @(posedge CLK_SYS or negedge RESETN)
    begin
        if (!RESETN)
        begin
            pin_meta_reg <= 2'h0;
            pin_sync_reg <= 2'h0;
        end
        else
        begin
            pin_meta_reg <= pin_meta_next;
            pin_sync_reg <= pin_sync_next;
        end
    end

    // *****************************************************************
    // reference and ceiling
    // *****************************************************************
    logic signed [23:0] ref_reg;     // resulting reference
    logic signed [23:0] ref_next;
    logic [15:0]        ceil_reg;    // current ceiling in 0.1 A
    logic [15:0]        ceil_next;
    logic [15:0]        ilim_reg;    // limited current demand
    logic [15:0]        ilim_next;
    logic signed [25:0] remote_sum;  // wide to avoid overflow
    logic [15:0]        nudge_pct;   // clamped nudge percent
    logic signed [43:0] nudge_amt;   // product before scaling
    logic [31:0]        ceil_prod;

    // form the remote reference, nudge it, and set the ceiling
    always_comb
    begin
        remote_sum = 26'(REFS.preset) + 26'(REFS.analogue)
                   + 26'(REFS.pulse) + 26'(REFS.serial);
        // out-of-range settings saturate at full scale
        nudge_pct = (NUDGE_PERCENT > `DLWM_PCT_FULL) ? `DLWM_PCT_FULL
                                                    : NUDGE_PERCENT;
        nudge_amt = 44'(remote_sum) * 44'(signed'({1'b0, nudge_pct}));
        nudge_amt = nudge_amt / 44'sd10000;
        ref_next  = remote_sum[23:0];
        // a catch-up on a negative sum moves it further from zero, a slow-down nearer to it
        // both requests together cancel out
        if (pin_sync_reg == 2'b01)
            ref_next = 24'(remote_sum + nudge_amt[25:0]);
        else if (pin_sync_reg == 2'b10)
            ref_next = 24'(remote_sum - nudge_amt[25:0]);
        ceil_prod = 32'(CEILING_PERCENT) * 32'(RATED_CURRENT);
        ceil_prod = ceil_prod / 32'd10000;
        ceil_next = (ceil_prod > 32'(MAX_CURRENT)) ? MAX_CURRENT
                                                   : ceil_prod[15:0];
        ilim_next = (REQ_CURRENT > ceil_reg) ? ceil_reg : REQ_CURRENT;
    end

    // register reference and ceiling
    always_ff @(posedge CLK_SYS or negedge RESETN)
    begin
        if (!RESETN)
        begin
            ref_reg  <= 24'sh000000;
            ceil_reg <= 16'h0000;
            ilim_reg <= 16'h0000;
        end
        else
        begin
            ref_reg  <= ref_next;
            ceil_reg <= ceil_next;
            ilim_reg <= ilim_next;
        end
    end

    // *****************************************************************
    // run state: warnings armed only at reference
    // *****************************************************************
    dlwm_pkg::dlwm_run_t run_reg;
    dlwm_pkg::dlwm_run_t run_next;
    logic                at_ref;     // frequency equals reference

    // track start, ramp and arrival
    always_comb
    begin
        at_ref   = !RAMPING && (24'(OUT_FREQ) == ref_reg);
        run_next = run_reg;
        // a stop request always wins over arrival at the reference
        unique case (run_reg)
            dlwm_pkg::DLWM_STOPPED:
                if (START_CMD)
                    run_next = dlwm_pkg::DLWM_RAMPING;
            dlwm_pkg::DLWM_RAMPING:
                if (!START_CMD)
                    run_next = dlwm_pkg::DLWM_STOPPED;
                else if (at_ref)
                    run_next = dlwm_pkg::DLWM_ON_REF;
            dlwm_pkg::DLWM_ON_REF:
                if (!START_CMD)
                    run_next = dlwm_pkg::DLWM_STOPPED;
                else if (RAMPING)
                    run_next = dlwm_pkg::DLWM_RAMPING;
            default:
                run_next = dlwm_pkg::DLWM_STOPPED;
        endcase
    end

    // register run state
    always_ff @(posedge CLK_SYS or negedge RESETN)
    begin
        if (!RESETN)
            run_reg <= dlwm_pkg::DLWM_STOPPED;
        else
            run_reg <= run_next;
    end

    // *****************************************************************
    // threshold comparison
    // *****************************************************************
    dlwm_pkg::dlwm_warn_t warn_reg;
    dlwm_pkg::dlwm_warn_t warn_next;
    logic [15:0]          cur_hi_c;  // clamped thresholds
    logic [15:0]          cur_lo_c;
    logic [15:0]          frq_top;
    logic [15:0]          frq_hi_c;
    logic [15:0]          frq_lo_c;
    logic signed [39:0]   fb_hi_c;
    logic signed [39:0]   fb_lo_c;
    logic                 armed;
    logic                 dout_reg;  // flag routed to the digital output
    logic                 dout_next;
    logic                 relay_reg; // flag routed to the relay
    logic                 relay_next;

    // clamp thresholds and compare; plain levels, no latching
    // clamping on use leaves the programmed settings untouched
    always_comb
    begin
        cur_hi_c = (CUR_WARN_HI > MAX_CURRENT) ? MAX_CURRENT : CUR_WARN_HI;
        cur_lo_c = (CUR_WARN_LO > cur_hi_c) ? cur_hi_c : CUR_WARN_LO;
        frq_top  = WIDE_FREQ_RANGE ? `DLWM_FREQ_MAX_HIGH : `DLWM_FREQ_MAX_LOW;
        frq_hi_c = (FRQ_WARN_HI > frq_top) ? frq_top : FRQ_WARN_HI;
        frq_lo_c = (FRQ_WARN_LO > frq_hi_c) ? frq_hi_c : FRQ_WARN_LO;
        fb_hi_c  = (FB_WARN_HI > `DLWM_FB_TOP) ? `DLWM_FB_TOP : FB_WARN_HI;
        fb_lo_c  = (FB_WARN_LO < `DLWM_FB_FLOOR) ? `DLWM_FB_FLOOR : FB_WARN_LO;
        if (fb_lo_c > fb_hi_c)
            fb_lo_c = fb_hi_c;
        armed = (run_reg == dlwm_pkg::DLWM_ON_REF);
        warn_next = '0;
        if (armed)
        begin
            warn_next[`DLWM_W_CUR_LO] = OUT_CURRENT < cur_lo_c;
            warn_next[`DLWM_W_CUR_HI] = OUT_CURRENT > cur_hi_c;
            warn_next[`DLWM_W_FRQ_LO] = OUT_FREQ < frq_lo_c;
            warn_next[`DLWM_W_FRQ_HI] = OUT_FREQ > frq_hi_c;
            warn_next[`DLWM_W_FB_LO]  = FEEDBACK < fb_lo_c;
            warn_next[`DLWM_W_FB_HI]  = FEEDBACK > fb_hi_c;
        end
        // routed copies follow the same flags, so the pins agree with them
        dout_next  = |(warn_next & DOUT_ROUTE);
        relay_next = |(warn_next & RELAY_ROUTE);
    end

    // register warnings, refreshed each cycle
    always_ff @(posedge CLK_SYS or negedge RESETN)
    begin
        if (!RESETN)
        begin
            warn_reg  <= '0;
            dout_reg  <= 1'b0;
            relay_reg <= 1'b0;
        end
        else
        begin
            warn_reg  <= warn_next;
            dout_reg  <= dout_next;
            relay_reg <= relay_next;
        end
    end

    // *****************************************************************
    // outputs
    // *****************************************************************
    // routed outputs are registered so a mask change cannot glitch the pins
    assign DOUT_WARN       = dout_reg;
    assign RELAY_WARN      = relay_reg;
    assign WARNINGS        = warn_reg;
    assign RESULT_REF      = ref_reg;
    assign CURRENT_LIMITED = ilim_reg;
    assign CURRENT_CEILING = ceil_reg;
    assign RUN_STATE       = run_reg;

    // *****************************************************************
    // assertions
    // *****************************************************************
    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (!RESETN);

    // reference nudging
    catchup_ref_a: assert property (pin_sync_reg == 2'b01 && nudge_amt > 0
        |=> ref_reg > $past(remote_sum)) else $error("catch-up not applied");
    slowdown_ref_a: assert property (pin_sync_reg == 2'b10 && nudge_amt > 0
        |=> ref_reg < $past(remote_sum)) else $error("slow-down not applied");
    // current limit and warning thresholds
    ceiling_hold_a: assert property (CURRENT_LIMITED <= $past(ceil_reg))
        else $error("current above ceiling");
    cur_lo_warn_a: assert property (armed && OUT_CURRENT < cur_lo_c
        |=> WARNINGS[`DLWM_W_CUR_LO]) else $error("low current missed");
    cur_hi_warn_a: assert property (armed && OUT_CURRENT > cur_hi_c
        |=> WARNINGS[`DLWM_W_CUR_HI]) else $error("high current missed");
    cur_order_a: assert property (cur_lo_c <= cur_hi_c && cur_hi_c <= MAX_CURRENT)
        else $error("current thresholds out of order");
    frq_warn_a: assert property (armed && OUT_FREQ > frq_hi_c
        |=> WARNINGS[`DLWM_W_FRQ_HI] && !WARNINGS[`DLWM_W_FRQ_LO])
        else $error("frequency warning wrong");
    fb_warn_a: assert property (armed && FEEDBACK < fb_lo_c
        |=> WARNINGS[`DLWM_W_FB_LO] && !WARNINGS[`DLWM_W_FB_HI])
        else $error("feedback warning wrong");
    stop_quiet_a: assert property (!START_CMD |=> ##1 WARNINGS == '0)
        else $error("warning while stopped");
    route_a: assert property (DOUT_WARN == |(WARNINGS & $past(DOUT_ROUTE)))
        else $error("output routing wrong");
    relay_route_a: assert property (RELAY_WARN == |(WARNINGS & $past(RELAY_ROUTE)))
        else $error("relay routing wrong");
    // arrival at the reference arms the comparisons on the next edge
    arm_on_ref_a: assert property (run_reg == dlwm_pkg::DLWM_RAMPING && START_CMD
        && at_ref |=> run_reg == dlwm_pkg::DLWM_ON_REF) else $error("arming missed");
    // without arming every flag must fall on the next edge
    quiet_unarmed_a: assert property (!armed |=> WARNINGS == '0)
        else $error("warning while unarmed");
    // the remaining one-sided warnings
    frq_lo_warn_a: assert property (armed && OUT_FREQ < frq_lo_c
        |=> WARNINGS[`DLWM_W_FRQ_LO]) else $error("low frequency missed");
    fb_hi_warn_a: assert property (armed && FEEDBACK > fb_hi_c
        |=> WARNINGS[`DLWM_W_FB_HI]) else $error("high feedback missed");
    // the ceiling may never pass the maximum output current
    ceiling_top_a: assert property (CURRENT_CEILING <= $past(MAX_CURRENT))
        else $error("ceiling above maximum current");
    fb_order_a: assert property (fb_lo_c <= fb_hi_c && fb_hi_c <= `DLWM_FB_TOP)
        else $error("feedback thresholds out of order");

    start_ramp_c: cover property (START_CMD ##1 run_reg == dlwm_pkg::DLWM_RAMPING
        ##[1:50] run_reg == dlwm_pkg::DLWM_ON_REF);
    any_warn_c: cover property (WARNINGS != '0);
    catchup_c: cover property (pin_sync_reg == 2'b01);
    relay_c: cover property (RELAY_WARN);
    // a stop taken straight from the armed state
    stop_c: cover property (run_reg == dlwm_pkg::DLWM_ON_REF
        ##1 run_reg == dlwm_pkg::DLWM_STOPPED);

endmodule : dlwm_monitor

// ===== tb_dlwm_monitor.sv
// self-checking testbench for the drive limit and warning monitor
`timescale 1ns/100ps
`include "dlwm_defines.svh"
module tb_dlwm_monitor;
    // one row of warning stimulus with its expected warning vector
    typedef struct packed {
        logic [15:0]        cur;
        logic [15:0]        clo;
        logic [15:0]        chi;
        logic [15:0]        flo;
        logic [15:0]        fhi;
        logic               wide;
        logic signed [39:0] fb;
        logic signed [39:0] fbhi;
        logic [5:0]         exp;
    } dlwm_tc_t;
    // *****************************************************************
    // signals and counters
    // *****************************************************************
    logic                    clk_sys, resetn, catch_up, slow_down, start_cmd, ramping, wide;
    dlwm_pkg::dlwm_refs_t    refs;
    logic [15:0]             nudge, out_freq, out_cur, req_cur, ceil_pct, rated, max_cur;
    logic [15:0]             cur_lo, cur_hi, frq_lo, frq_hi;
    logic signed [39:0]      feedback, fb_lo, fb_hi;
    logic [5:0]              dout_route, relay_route;
    logic signed [23:0]      result_ref;
    logic [15:0]             cur_limited, cur_ceiling;
    dlwm_pkg::dlwm_warn_t    warnings;
    logic                    dout_warn, relay_warn;
    dlwm_pkg::dlwm_run_t     run_state;
    int                      n_fail = 0;  // mismatches
    int                      n_tests = 0; // comparisons made
    // all rows run at 140.0 Hz on reference with route masks 02 and 3c
    dlwm_tc_t tc [13] = '{
        '{16'hc8, 16'h64, 16'h190, 16'h0, 16'h7d0, 1'b1, 40'sh0, 40'sh3d0900, 6'h00},
        '{16'h32, 16'h64, 16'h190, 16'h0, 16'h7d0, 1'b1, 40'sh0, 40'sh3d0900, 6'h01},
        '{16'h1c2, 16'h64, 16'h190, 16'h0, 16'h7d0, 1'b1, 40'sh0, 40'sh3d0900, 6'h02},
        '{16'h1c2, 16'h64, 16'h3e8, 16'h0, 16'h7d0, 1'b1, 40'sh0, 40'sh3d0900, 6'h00},
        '{16'hfa, 16'h12c, 16'hc8, 16'h0, 16'h7d0, 1'b1, 40'sh0, 40'sh3d0900, 6'h02},
        '{16'hc8, 16'h64, 16'h190, 16'h7d0, 16'hbb8, 1'b1, 40'sh0, 40'sh3d0900, 6'h04},
        '{16'hc8, 16'h64, 16'h190, 16'h1388, 16'h528, 1'b0, 40'sh0, 40'sh3d0900, 6'h08},
        '{16'hc8, 16'h64, 16'h190, 16'h0, 16'h4e20, 1'b0, 40'sh0, 40'sh3d0900, 6'h08},
        '{16'hc8, 16'h64, 16'h190, 16'h0, 16'h4e20, 1'b1, 40'sh0, 40'sh3d0900, 6'h00},
        '{16'hc8, 16'h64, 16'h190, 16'h0, 16'h7d0, 1'b1, 40'sh4c4b40, 40'sh3d0900, 6'h20},
        '{16'hc8, 16'h64, 16'h190, 16'h0, 16'h7d0, 1'b1, -40'sh4c4b40, 40'sh3d0900, 6'h10},
        '{16'hc8, 16'h64, 16'h190, 16'h0, 16'h7d0, 1'b1, 40'sh8f0d180, 40'shbebc200, 6'h20},
        '{16'h32, 16'h64, 16'h190, 16'h0, 16'h7d0, 1'b1, 40'sh4c4b40, 40'sh3d0900, 6'h21}
    };
    // *****************************************************************
    // design under test and clock
    // *****************************************************************
    dlwm_monitor dlwm_monitor_i (
        .CLK_SYS(clk_sys), .RESETN(resetn), .REFS(refs), .CATCH_UP_PIN(catch_up),
        .SLOW_DOWN_PIN(slow_down), .NUDGE_PERCENT(nudge), .START_CMD(start_cmd),
        .RAMPING(ramping), .OUT_FREQ(out_freq), .OUT_CURRENT(out_cur), .REQ_CURRENT(req_cur),
        .FEEDBACK(feedback), .CEILING_PERCENT(ceil_pct), .RATED_CURRENT(rated),
        .MAX_CURRENT(max_cur), .CUR_WARN_LO(cur_lo), .CUR_WARN_HI(cur_hi),
        .WIDE_FREQ_RANGE(wide), .FRQ_WARN_LO(frq_lo), .FRQ_WARN_HI(frq_hi),
        .FB_WARN_LO(fb_lo), .FB_WARN_HI(fb_hi), .DOUT_ROUTE(dout_route),
        .RELAY_ROUTE(relay_route), .RESULT_REF(result_ref), .CURRENT_LIMITED(cur_limited),
        .CURRENT_CEILING(cur_ceiling), .WARNINGS(warnings), .DOUT_WARN(dout_warn),
        .RELAY_WARN(relay_warn), .RUN_STATE(run_state));
    // 200 MHz system clock
    always #2.5 clk_sys = ~clk_sys;
    // *****************************************************************
    // shared tasks
    // *****************************************************************
    // compare with case equality so an unknown never passes
    task automatic check(input string name, input logic [39:0] seen, input logic [39:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("unexpected %s expected %h seen %h", name, exp, seen);
        end
    endtask : check
    // let n edges pass, then step clear of the edge before sampling
    task automatic wait_cyc(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask : wait_cyc
    // drive the pins; the synchroniser adds two cycles, so wait five
    task automatic pins(input logic cu, input logic sd, input logic [23:0] exp);
        @(posedge clk_sys);
        catch_up  <= cu;
        slow_down <= sd;
        wait_cyc(5);
        check("result_ref", {16'h0000, result_ref}, {16'h0000, exp});
    endtask : pins
    // one place prints the counts and the verdict
    task automatic complete_run;
        $display("comparisons %0d mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : complete_run
    // watchdog: the sequence needs a few hundred cycles at most
    initial
    begin
        #200000;
        n_fail++;
        complete_run();
    end
    // *****************************************************************
    // main sequence
    // *****************************************************************
    initial
    begin
        clk_sys     = 1'b0;
        resetn      = 1'b0;
        catch_up    = 1'b0;
        slow_down   = 1'b0;
        start_cmd   = 1'b0;
        ramping     = 1'b1;
        wide        = 1'b1;
        nudge       = 16'h03e8;
        out_freq    = 16'h0578;
        out_cur     = 16'h0032;
        refs        = '{24'sh3e8, 24'sh12c, 24'sh96, -24'sh32};
        req_cur     = 16'h01ea;
        ceil_pct    = `DLWM_CEIL_DEFAULT;
        rated       = 16'h012c;
        max_cur     = 16'h01f4;
        cur_lo      = 16'h0064;
        cur_hi      = 16'h0190;
        frq_lo      = 16'h0000;
        frq_hi      = 16'h07d0;
        feedback    = 40'sh0;
        fb_lo       = `DLWM_FB_LO_DEFAULT;
        fb_hi       = `DLWM_FB_HI_DEFAULT;
        dout_route  = 6'h02;
        relay_route = 6'h3c;
        wait_cyc(16);
        check("reset_state", {38'h0, run_state}, {38'h0, dlwm_pkg::DLWM_STOPPED});
        check("reset_warn", {34'h0, warnings}, 40'h0);
        @(posedge clk_sys);
        resetn <= 1'b1;
        // start while the ramp still moves: no warning despite low current
        start_cmd <= 1'b1;
        wait_cyc(4);
        check("ramp_state", {38'h0, run_state}, {38'h0, dlwm_pkg::DLWM_RAMPING});
        check("ramp_warn", {34'h0, warnings}, 40'h0);
        @(posedge clk_sys);
        ramping <= 1'b0;
        wait_cyc(4);
        check("onref_state", {38'h0, run_state}, {38'h0, dlwm_pkg::DLWM_ON_REF});
        check("onref_warn", {34'h0, warnings}, 40'h1);
        // each table row, with the routed outputs derived from the masks
        for (int i = 0; i < 13; i++)
        begin
            @(posedge clk_sys);
            out_cur  <= tc[i].cur;
            cur_lo   <= tc[i].clo;
            cur_hi   <= tc[i].chi;
            frq_lo   <= tc[i].flo;
            frq_hi   <= tc[i].fhi;
            wide     <= tc[i].wide;
            feedback <= tc[i].fb;
            fb_hi    <= tc[i].fbhi;
            wait_cyc(4);
            check("warnings", {34'h0, warnings}, {34'h0, tc[i].exp});
            check("dout_warn", {39'h0, dout_warn}, {39'h0, |(tc[i].exp & 6'h02)});
            check("relay_warn", {39'h0, relay_warn}, {39'h0, |(tc[i].exp & 6'h3c)});
        end
        // a lower feedback limit under the floor is raised to the floor
        @(posedge clk_sys);
        fb_lo    <= -40'shbebc200;
        feedback <= -40'sh8f0d180;
        wait_cyc(4);
        check("fb_floor", {34'h0, warnings}, 40'h11);
        // ramping again drops arming, settling re-arms it; stop clears all
        @(posedge clk_sys);
        ramping <= 1'b1;
        wait_cyc(4);
        check("reramp_warn", {34'h0, warnings}, 40'h0);
        @(posedge clk_sys);
        ramping <= 1'b0;
        wait_cyc(4);
        check("rearm_warn", {34'h0, warnings}, 40'h11);
        @(posedge clk_sys);
        start_cmd <= 1'b0;
        wait_cyc(3);
        check("stop_state", {38'h0, run_state}, {38'h0, dlwm_pkg::DLWM_STOPPED});
        check("stop_warn", {34'h0, warnings}, 40'h0);
        // nudge of 10 % on a 140.0 Hz sum, then both pins, then over-range percent
        pins(1'b0, 1'b0, 24'h000578);
        pins(1'b1, 1'b0, 24'h000604);
        pins(1'b0, 1'b1, 24'h0004ec);
        pins(1'b1, 1'b1, 24'h000578);
        @(posedge clk_sys);
        nudge <= 16'h4e20;
        pins(1'b1, 1'b0, 24'h000af0);
        // 160 % of 30.0 A is 48.0 A, below the 50.0 A maximum
        check("ceiling", {24'h0, cur_ceiling}, {24'h0, 16'h01e0});
        check("limited", {24'h0, cur_limited}, {24'h0, 16'h01e0});
        @(posedge clk_sys);
        ceil_pct <= 16'h4e20;
        req_cur  <= 16'h0064;
        wait_cyc(3);
        check("ceiling_max", {24'h0, cur_ceiling}, {24'h0, 16'h01f4});
        check("limited_pass", {24'h0, cur_limited}, {24'h0, 16'h0064});
        complete_run();
    end
endmodule : tb_dlwm_monitor
